// ===== pkg/dfls_regs.vh
`ifndef DFLS_REGS_VH
`define DFLS_REGS_VH

// register indices (byte address is four times the index)
`define DFLS_ADDR_CTRL 4'h0
`define DFLS_ADDR_OFF_DELAY 4'h1
`define DFLS_ADDR_HOLD 4'h2
`define DFLS_ADDR_PW_LEAD 4'h3
`define DFLS_ADDR_PW_DUR 4'h4
`define DFLS_ADDR_STATUS 4'h5
`define DFLS_ADDR_ELAPSED 4'h6
`define DFLS_ADDR_SRC 4'h7
`define DFLS_ADDR_SRC_BLOCK 4'h8

// control register fields
`define DFLS_CTRL_PW_EN 0
`define DFLS_CTRL_RETAIN 1
`define DFLS_CTRL_TB_LO 2
`define DFLS_CTRL_TB_HI 3

// timebase codes: 10 ms, 100 ms, 1 s, 1 min
`define DFLS_TB_10MS 2'h0
`define DFLS_TB_100MS 2'h1
`define DFLS_TB_1S 2'h2
`define DFLS_TB_1MIN 2'h3

// timebase periods in microseconds
`define DFLS_T_10MS_US 10000
`define DFLS_T_100MS_US 100000
`define DFLS_T_1S_US 1000000
`define DFLS_T_1MIN_US 60000000
`define DFLS_CLK_MHZ 20

// reset values of times, in timebase units
`define DFLS_RST_OFF_DELAY 16'h0064
`define DFLS_RST_HOLD 16'h0032
`define DFLS_RST_PW_LEAD 16'h000a
`define DFLS_RST_PW_DUR 16'h0005

// status bit positions
`define DFLS_ST_OUT 0
`define DFLS_ST_PERM 1
`define DFLS_ST_DELAY 2
`define DFLS_ST_HOLD 3
`define DFLS_ST_WARN 4

`endif

// ===== design/dfls_tick.v
`timescale 1ns/1ns
`include "dfls_regs.vh"

// -----------------------------------------------------------------------
// timebase prescaler: one-cycle tick per selected unit
// -----------------------------------------------------------------------
module dfls_tick #(
    parameter DIV_10MS = (`DFLS_T_10MS_US * `DFLS_CLK_MHZ),
    parameter DIV_100MS = (`DFLS_T_100MS_US * `DFLS_CLK_MHZ),
    parameter DIV_1S = (`DFLS_T_1S_US * `DFLS_CLK_MHZ),
    parameter DIV_1MIN = (`DFLS_T_1MIN_US * `DFLS_CLK_MHZ)
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire restart_i,
    input wire [1:0] sel_i,
    output reg tick_o
);
    reg [31:0] cnt_q;
    reg [31:0] div;

    always @* begin
        case (sel_i)
            `DFLS_TB_10MS: div = DIV_10MS;
            `DFLS_TB_100MS: div = DIV_100MS;
            `DFLS_TB_1S: div = DIV_1S;
            default: div = DIV_1MIN;
        endcase
    end

    // restart aligns the first unit to the start of a timing phase
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_q + 32'h1 >= div) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== design/dfls_switch.v
`timescale 1ns/1ns
`include "dfls_regs.vh"

// Overview of operation
// - trigger rising edge sets the output
// - hold trigger long enough gives permanent light
// - early release starts off-delay from zero
// - output clears when elapsed reaches or passes off-delay
// - optional pre-warning blanks output before end
// - further trigger while active switches off
// - clear input zeroes time and output
// - retention keeps output and time on power loss
// - retention setting: slash none, R retained
// - times may come from another block's value
// - elapsed shows hold or off-delay count
module dfls_switch #(
    parameter TW = 16,
    parameter BLKW = 8,
    parameter DIV_10MS = (`DFLS_T_10MS_US * `DFLS_CLK_MHZ),
    parameter DIV_100MS = (`DFLS_T_100MS_US * `DFLS_CLK_MHZ),
    parameter DIV_1S = (`DFLS_T_1S_US * `DFLS_CLK_MHZ),
    parameter DIV_1MIN = (`DFLS_T_1MIN_US * `DFLS_CLK_MHZ)
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire power_good_i,
    input wire trigger_in_i,
    input wire clear_input_i,
    input wire [TW-1:0] ext_time_i,
    output reg [BLKW-1:0] ext_block_o,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg switch_output_o
);
    // -------------------------------------------------------------------
    // state machine codes
    // -------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_DELAY = 2'h2;
    localparam ST_PERM = 2'h3;

    // -------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------
    reg trg_m_q, trg_s_q, trg_p_q;
    reg clr_m_q, clr_s_q;
    reg pg_m_q, pg_s_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trg_m_q <= 1'b0;
            trg_s_q <= 1'b0;
            trg_p_q <= 1'b0;
            clr_m_q <= 1'b0;
            clr_s_q <= 1'b0;
            pg_m_q <= 1'b0;
            pg_s_q <= 1'b0;
        end else begin
            trg_m_q <= trigger_in_i;
            trg_s_q <= trg_m_q;
            trg_p_q <= trg_s_q;
            clr_m_q <= clear_input_i;
            clr_s_q <= clr_m_q;
            pg_m_q <= power_good_i;
            pg_s_q <= pg_m_q;
        end
    end

    wire trg_rise = trg_s_q & ~trg_p_q;
    wire trg_fall = ~trg_s_q & trg_p_q;
    wire clr = clr_s_q;
    // power_good syncs as low out of reset: the first cycles read as a failure
    wire pfail = ~pg_s_q;

    // -------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------
    reg pw_en_q, retain_q;
    reg [1:0] tb_q;
    reg [TW-1:0] off_delay_q, hold_q, lead_q, dur_q;
    reg [3:0] src_q; // per time: 0 fixed, 1 live value of other block
    reg [BLKW-1:0] blk_d0_q, blk_d1_q, blk_d2_q, blk_d3_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pw_en_q <= 1'b0;
            retain_q <= 1'b0;
            tb_q <= `DFLS_TB_1S;
            off_delay_q <= `DFLS_RST_OFF_DELAY;
            hold_q <= `DFLS_RST_HOLD;
            lead_q <= `DFLS_RST_PW_LEAD;
            dur_q <= `DFLS_RST_PW_DUR;
            src_q <= 4'h0;
            blk_d0_q <= {BLKW{1'b0}};
            blk_d1_q <= {BLKW{1'b0}};
            blk_d2_q <= {BLKW{1'b0}};
            blk_d3_q <= {BLKW{1'b0}};
        end else if (wr_i) begin
            case (addr_i)
                `DFLS_ADDR_CTRL: begin
                    pw_en_q <= wdata_i[`DFLS_CTRL_PW_EN];
                    retain_q <= wdata_i[`DFLS_CTRL_RETAIN];
                    tb_q <= wdata_i[`DFLS_CTRL_TB_HI:`DFLS_CTRL_TB_LO];
                end
                `DFLS_ADDR_OFF_DELAY: off_delay_q <= wdata_i[TW-1:0];
                `DFLS_ADDR_HOLD: hold_q <= wdata_i[TW-1:0];
                `DFLS_ADDR_PW_LEAD: lead_q <= wdata_i[TW-1:0];
                `DFLS_ADDR_PW_DUR: dur_q <= wdata_i[TW-1:0];
                `DFLS_ADDR_SRC: src_q <= wdata_i[3:0];
                `DFLS_ADDR_SRC_BLOCK: begin
                    blk_d0_q <= wdata_i[BLKW-1:0];
                    blk_d1_q <= wdata_i[BLKW+7:8];
                    blk_d2_q <= wdata_i[BLKW+15:16];
                    blk_d3_q <= wdata_i[BLKW+23:24];
                end
                default: begin
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // live-value sourcing: block number scanned round robin
    // -------------------------------------------------------------------
    // one shared fetch port; each time refreshes every fourth cycle,
    // trading latency for a single external mux
    reg [1:0] scan_q;
    reg [1:0] cap_q;
    wire [TW-1:0] fixed_t [0:3];
    wire [TW-1:0] pick_t [0:3];

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_q <= 2'h0;
            cap_q <= 2'h0;
            ext_block_o <= {BLKW{1'b0}};
        end else begin
            scan_q <= scan_q + 2'h1;
            cap_q <= scan_q;
            case (scan_q)
                2'h0: ext_block_o <= blk_d0_q;
                2'h1: ext_block_o <= blk_d1_q;
                2'h2: ext_block_o <= blk_d2_q;
                default: ext_block_o <= blk_d3_q;
            endcase
        end
    end

    assign fixed_t[0] = off_delay_q;
    assign fixed_t[1] = hold_q;
    assign fixed_t[2] = lead_q;
    assign fixed_t[3] = dur_q;

    // a block number stands on ext_block_o one cycle before its value is
    // captured, so each slot samples in the cycle in which cap_q names it
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_live
            reg [TW-1:0] live_q;
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    live_q <= {TW{1'b0}};
                end else if (cap_q == gi) begin
                    live_q <= ext_time_i;
                end
            end
            assign pick_t[gi] = src_q[gi] ? live_q : fixed_t[gi];
        end
    endgenerate

    wire [TW-1:0] t_off = pick_t[0];
    wire [TW-1:0] t_hold = pick_t[1];
    wire [TW-1:0] t_lead = pick_t[2];
    wire [TW-1:0] t_dur = pick_t[3];

    // -------------------------------------------------------------------
    // timebase
    // -------------------------------------------------------------------
    reg [1:0] state_q, state_d;
    reg [TW-1:0] elapsed_q, elapsed_d;
    reg out_q, out_d;
    reg restart;
    wire tick;

    dfls_tick #(
        .DIV_10MS(DIV_10MS),
        .DIV_100MS(DIV_100MS),
        .DIV_1S(DIV_1S),
        .DIV_1MIN(DIV_1MIN)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .restart_i(restart),
        .sel_i(tb_q),
        .tick_o(tick)
    );

    // -------------------------------------------------------------------
    // switch sequencing
    // -------------------------------------------------------------------
    wire [TW-1:0] warn_start = t_off - t_lead;
    wire [TW-1:0] warn_end = warn_start + t_dur;
    // gated by state so a stale count cannot flag a warning when idle
    wire in_warn = (state_q == ST_DELAY) && pw_en_q && (t_lead <= t_off) &&
                   (elapsed_q >= warn_start) && (elapsed_q < warn_end);

    // clear outranks every trigger edge; a retrigger switches off, never restarts
    always @* begin
        state_d = state_q;
        elapsed_d = elapsed_q;
        out_d = out_q;
        restart = 1'b0;
        if (clr) begin
            state_d = ST_IDLE;
            elapsed_d = {TW{1'b0}};
            out_d = 1'b0;
            restart = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trg_rise) begin
                        state_d = ST_HOLD;
                        out_d = 1'b1;
                        elapsed_d = {TW{1'b0}};
                        restart = 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (trg_fall) begin
                        state_d = ST_DELAY;
                        elapsed_d = {TW{1'b0}};
                        restart = 1'b1;
                    end else if (elapsed_q >= t_hold) begin
                        state_d = ST_PERM;
                        elapsed_d = {TW{1'b0}};
                    end else if (tick) begin
                        elapsed_d = elapsed_q + {{(TW-1){1'b0}}, 1'b1};
                    end
                end
                ST_DELAY: begin
                    // compare with >=: a live off-delay may drop below the count
                    if (trg_rise) begin
                        state_d = ST_IDLE;
                        elapsed_d = {TW{1'b0}};
                        out_d = 1'b0;
                    end else if (elapsed_q >= t_off) begin
                        state_d = ST_IDLE;
                        out_d = 1'b0;
                    end else begin
                        out_d = ~in_warn;
                        if (tick) begin
                            elapsed_d = elapsed_q + {{(TW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_PERM: begin
                    out_d = 1'b1;
                    if (trg_rise) begin
                        state_d = ST_IDLE;
                        elapsed_d = {TW{1'b0}};
                        out_d = 1'b0;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    out_d = 1'b0;
                end
            endcase
        end
    end

    // power failure: state is frozen if retained, else wiped
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            elapsed_q <= {TW{1'b0}};
            out_q <= 1'b0;
        end else if (pfail) begin
            if (!retain_q) begin
                state_q <= ST_IDLE;
                elapsed_q <= {TW{1'b0}};
                out_q <= 1'b0;
            end
        end else begin
            state_q <= state_d;
            elapsed_q <= elapsed_d;
            out_q <= out_d;
        end
    end

    // -------------------------------------------------------------------
    // lamp output
    // -------------------------------------------------------------------
    // taken from the next state so the lamp follows a trigger edge one
    // cycle sooner; masked while power is bad, whatever is retained
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            switch_output_o <= 1'b0;
        end else begin
            switch_output_o <= out_d & ~pfail;
        end
    end

    // -------------------------------------------------------------------
    // register read
    // -------------------------------------------------------------------
    // bit order is set by the status field defines, not by this vector
    wire [4:0] status = {state_q == ST_HOLD, state_q == ST_DELAY,
                         state_q == ST_PERM, in_warn, out_q};
    wire [4:0] status_bits;
    assign status_bits[`DFLS_ST_OUT] = status[0];
    assign status_bits[`DFLS_ST_WARN] = status[1];
    assign status_bits[`DFLS_ST_PERM] = status[2];
    assign status_bits[`DFLS_ST_DELAY] = status[3];
    assign status_bits[`DFLS_ST_HOLD] = status[4];

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `DFLS_ADDR_CTRL: rdata_o <= {28'h0, tb_q, retain_q, pw_en_q};
                `DFLS_ADDR_OFF_DELAY: rdata_o <= {{(32-TW){1'b0}}, off_delay_q};
                `DFLS_ADDR_HOLD: rdata_o <= {{(32-TW){1'b0}}, hold_q};
                `DFLS_ADDR_PW_LEAD: rdata_o <= {{(32-TW){1'b0}}, lead_q};
                `DFLS_ADDR_PW_DUR: rdata_o <= {{(32-TW){1'b0}}, dur_q};
                `DFLS_ADDR_STATUS: rdata_o <= {27'h0, status_bits};
                `DFLS_ADDR_ELAPSED: rdata_o <= {{(32-TW){1'b0}}, elapsed_q};
                `DFLS_ADDR_SRC: rdata_o <= {28'h0, src_q};
                `DFLS_ADDR_SRC_BLOCK: rdata_o <= {blk_d3_q, blk_d2_q, blk_d1_q, blk_d0_q};
                default: rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end
endmodule

// ===== testbench/dfls_switch_checker.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// port-level checks of the switch
// ------------------------------------------------------------
module dfls_switch_checker #(
    parameter TW = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire power_good_i,
    input wire trigger_in_i,
    input wire clear_input_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire switch_output_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_dark;
        !switch_output_o [*8];
    endsequence
    sequence s_lit;
        switch_output_o [*2];
    endsequence
    sequence s_clean_rise;
        $rose(trigger_in_i) && power_good_i && !clear_input_i;
    endsequence
    sequence s_cleared;
        clear_input_i [*4];
    endsequence
    sequence s_wr_rd;
        (wr_i && addr_i >= 4'h1 && addr_i <= 4'h4) ##1 (rd_i && addr_i == $past(addr_i));
    endsequence

    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 4'h8 |-> rdata_o == 32'h0)
        else $error("unmapped index read nonzero");
    a_time_readback: assert property (s_wr_rd |=> rdata_o == ($past(wdata_i, 2) & ((32'h1 << TW) - 32'h1)))
        else $error("time register readback wrong");
    a_trig_lights: assert property (s_dark ##0 s_clean_rise |-> ##[2:4] switch_output_o)
        else $error("trigger edge did not light output");
    a_retrig_dark: assert property (s_lit ##0 s_clean_rise |-> ##[3:5] !switch_output_o)
        else $error("further trigger did not switch off");
    a_clear_dark: assert property (s_cleared |=> !switch_output_o)
        else $error("output lit while clear held");
    a_clear_zero: assert property (s_cleared ##0 (rd_i && addr_i == 4'h6) |=> rdata_o == 32'h0)
        else $error("elapsed time not zero under clear");
    a_power_dark: assert property (!power_good_i [*4] |=> !switch_output_o)
        else $error("output lit during power failure");
endmodule

// ===== testbench/dfls_partner.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// other function blocks offering live time values
// ------------------------------------------------------------
module dfls_partner #(
    parameter LIVE_BLOCK = 8'h03,
    parameter LIVE_VALUE = 16'h0006
) (
    input wire clk_i,
    input wire [7:0] ext_block_i,
    output logic [15:0] ext_time_o
);
    logic [15:0] churn_q = 16'h0;

    // unconfigured blocks show a moving value so a stale fetch cannot pass
    always @(posedge clk_i) churn_q <= churn_q + 16'h1357;

    // live value is given in the same timebase as the switch's own times
    always_comb begin
        if (ext_block_i == LIVE_BLOCK)
            ext_time_o = LIVE_VALUE;
        else
            ext_time_o = churn_q;
    end
endmodule

// ===== testbench/dual_function_light_switch_tb.sv
`timescale 1ns/1ns
`include "dfls_regs.vh"
module dual_function_light_switch_tb;
    logic clk_i = 1'b0;
    logic rst_n_i, power_good_i, trigger_in_i, clear_input_i, wr_i, rd_i;
    logic [3:0] addr_i;
    logic [31:0] wdata_i, d;
    wire [31:0] rdata_o;
    wire switch_output_o;
    wire [15:0] ext_time_i;
    wire [7:0] ext_block_o;
    integer fail_count = 0;
    integer check_count = 0;

    always #25 clk_i = ~clk_i;

    // short prescalers, all distinct so a wrong timebase code shows; 1 s ticks each 4 clocks
    dfls_switch #(.DIV_10MS(2), .DIV_100MS(3), .DIV_1S(4), .DIV_1MIN(5)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .power_good_i(power_good_i),
        .trigger_in_i(trigger_in_i), .clear_input_i(clear_input_i),
        .ext_time_i(ext_time_i), .ext_block_o(ext_block_o), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .switch_output_o(switch_output_o));
    dfls_partner i_far (.clk_i(clk_i), .ext_block_i(ext_block_o), .ext_time_o(ext_time_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task give_verdict;
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task pulse(input integer n);
        trigger_in_i <= 1'b1;
        cyc(n);
        trigger_in_i <= 1'b0;
        cyc(1);
    endtask
    // bounded wait; the caller judges the level reached
    task wait_out(input logic v, input integer n);
        integer i;
        for (i = 0; i < n && switch_output_o !== v; i++) cyc(1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd(`DFLS_ADDR_CTRL); chk(d, 32'h8);
        rd(`DFLS_ADDR_OFF_DELAY); chk(d, {16'h0, `DFLS_RST_OFF_DELAY});
        rd(`DFLS_ADDR_HOLD); chk(d, {16'h0, `DFLS_RST_HOLD});
        rd(`DFLS_ADDR_PW_LEAD); chk(d, {16'h0, `DFLS_RST_PW_LEAD});
        rd(`DFLS_ADDR_PW_DUR); chk(d, {16'h0, `DFLS_RST_PW_DUR});
        wr(4'hf, 32'h1234); rd(4'hf); chk(d, 32'h0);
        wr(`DFLS_ADDR_CTRL, 32'ha); rd(`DFLS_ADDR_CTRL); chk(d, 32'ha);
        wr(`DFLS_ADDR_CTRL, 32'h8);
        wr(4'h1, 32'd20); rd(4'h1); chk(d, 32'd20);
        wr(4'h2, 32'd10); rd(4'h2); chk(d, 32'd10);
        wr(4'h3, 32'd6); rd(4'h3); chk(d, 32'd6);
        wr(4'h4, 32'd3); rd(4'h4); chk(d, 32'd3);
    endtask
    task t_short;
        cyc(10); trigger_in_i <= 1'b1; cyc(6); chk(switch_output_o, 1'b1);
        cyc(14); trigger_in_i <= 1'b0; cyc(9);
        rd(`DFLS_ADDR_ELAPSED); chk(d >= 32'h1 && d <= 32'h4, 1'b1);
        cyc(40); chk(switch_output_o, 1'b1);
        wait_out(1'b0, 50); chk(switch_output_o, 1'b0);
    endtask
    task t_perm;
        cyc(10); pulse(60); cyc(120); chk(switch_output_o, 1'b1);
        rd(`DFLS_ADDR_STATUS); chk(d[`DFLS_ST_PERM], 1'b1);
        pulse(8); wait_out(1'b0, 8); chk(switch_output_o, 1'b0);
        cyc(100); chk(switch_output_o, 1'b0);
    endtask
    task t_clear;
        cyc(10); pulse(8); cyc(20); pulse(8);
        wait_out(1'b0, 8); chk(switch_output_o, 1'b0);
        cyc(10); pulse(8); cyc(10); clear_input_i <= 1'b1; cyc(5);
        rd(`DFLS_ADDR_ELAPSED); chk(d, 32'h0);
        chk(switch_output_o, 1'b0);
        clear_input_i <= 1'b0; cyc(100); chk(switch_output_o, 1'b0);
    endtask
    task t_warn;
        integer n;
        wr(`DFLS_ADDR_CTRL, 32'h9); cyc(10); pulse(8);
        cyc(40); chk(switch_output_o, 1'b1);
        wait_out(1'b0, 30); chk(switch_output_o, 1'b0);
        for (n = 0; n < 30 && switch_output_o === 1'b0; n++) cyc(1);
        chk(n >= 9 && n <= 15, 1'b1);
        cyc(4); chk(switch_output_o, 1'b1);
        wait_out(1'b0, 40); chk(switch_output_o, 1'b0);
        wr(`DFLS_ADDR_CTRL, 32'h8);
    endtask
    task t_ext;
        wr(4'h1, 32'd200); wr(`DFLS_ADDR_SRC, 32'h1); wr(`DFLS_ADDR_SRC_BLOCK, 32'h3);
        cyc(10); pulse(8); chk(switch_output_o, 1'b1);
        wait_out(1'b0, 80); chk(switch_output_o, 1'b0);
        wr(`DFLS_ADDR_SRC, 32'h0); wr(4'h1, 32'd20);
    endtask
    // finest timebase halves the off-delay against the 1 s unit
    task t_tbase;
        wr(`DFLS_ADDR_CTRL, 32'h0); cyc(10); pulse(8);
        cyc(36); chk(switch_output_o, 1'b1);
        cyc(10); chk(switch_output_o, 1'b0);
        wr(`DFLS_ADDR_CTRL, 32'h8);
    endtask
    task t_power;
        integer r;
        for (r = 0; r < 2; r++) begin
            wr(`DFLS_ADDR_CTRL, 32'h8 | (r << 1)); cyc(10); pulse(8); cyc(20);
            power_good_i <= 1'b0; cyc(10); chk(switch_output_o, 1'b0);
            power_good_i <= 1'b1; cyc(8); chk(switch_output_o, r[0]);
            rd(`DFLS_ADDR_ELAPSED); chk(d != 32'h0, r[0]);
            wait_out(1'b0, 100);
        end
    endtask

    initial begin
        rst_n_i = 1'b0; power_good_i = 1'b1; trigger_in_i = 1'b0; clear_input_i = 1'b0;
        wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 32'h0;
        cyc(6); rst_n_i <= 1'b1; cyc(2);
        t_regs; t_short; t_perm; t_clear; t_warn; t_ext; t_tbase; t_power;
        give_verdict;
    end
    // the whole sequence needs under 2000 clocks
    initial begin
        #(20000 * 50);
        fail_count++;
        give_verdict;
    end
endmodule

bind dfls_switch dfls_switch_checker #(.TW(TW)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .power_good_i(power_good_i),
    .trigger_in_i(trigger_in_i), .clear_input_i(clear_input_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .switch_output_o(switch_output_o));
